// [fsac_pkg.sv]
// Purpose: Constants and types for the fan speed and alarm controller
// Assumes: 10 MHz clock, temperatures in whole degrees C, volts in 0.1 V
// Notes on behaviour
// RULE_01: Any speed command write switches control to command mode.
// RULE_02: Command mode sets one common setpoint from the latest command.
// RULE_03: Temperature mode sets the common voltage from the selected sensor.
// RULE_04: Register full_speed_temperature_setting holds control temperature; at or above it, full voltage.
// RULE_05: Bus selects a 5 or 10 degree ramp span below control temperature.
// RULE_06: Bus selects remote or on-board sensor as the control input.
// RULE_07: With off temperature enabled, regulator off below that setpoint.
// RULE_08: Above alarm temperature raise over-temperature alarm and full voltage.
// RULE_09: Fan count 1 to 9; only that many fans powered and monitored.
// RULE_10: Setpoint is zero or within 12 to 24 volts, nothing between.
// RULE_11: Reset default: temperature mode, remote sensor, 40 C, 5 C span.
// RULE_12: Default configuration idles near 13 volts below 35 C.
// RULE_13: Default fan alarm below 2000 pulses per minute, nine fans.
// RULE_14: Default LED and relay alarms for fan alarm and open remote sensor.
// RULE_15: Fan, temperature, sensor, controller, power faults OR into alarms.
// RULE_16: Sensor status and temperatures readable over the bus.
// RULE_17: Regulator-off command from the bus disables the regulator output.
// RULE_18: Per-fan pass or fail status readable by the bus master.
// RULE_19: A disabled fan channel always reports no alarm.
// RULE_20: In command mode temperatures stay readable but steer nothing.
// RULE_21: Tach pulses counted per window, compared once per window.
package fsac_pkg;
  localparam int NUM_FANS = 9;
  localparam logic [7:0] REG_CTRL = 8'hf0;
  localparam logic [7:0] REG_OFF_TEMP = 8'hf1;
  localparam logic [7:0] REG_ALARM_TEMP = 8'hf2;
  localparam logic [7:0] REG_FAN_COUNT = 8'hf3;
  localparam logic [7:0] REG_SPEED_CMD = 8'hf4;
  localparam logic [7:0] REG_STATUS = 8'hf5;
  localparam logic [7:0] REG_REMOTE_TEMP = 8'hf6;
  localparam logic [7:0] REG_LOCAL_TEMP = 8'hf7;
  localparam logic [7:0] REG_SENSOR_STAT = 8'hf8;
  localparam logic [7:0] REG_FULL_SPEED_TEMP = 8'hf9;
  localparam logic [7:0] REG_FAN_FAIL_LO = 8'hfa;
  localparam logic [7:0] REG_FAN_FAIL_HI = 8'hfb;
  // Control register bit positions
  localparam int CTRL_SENSOR_LOCAL = 0;
  localparam int CTRL_SLOPE_10 = 1;
  localparam int CTRL_REG_OFF = 2;
  localparam int CTRL_OFF_EN = 3;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_FULL_SPEED_TEMP = 8'h28;
  localparam logic [7:0] RST_OFF_TEMP = 8'h00;
  localparam logic [7:0] RST_ALARM_TEMP = 8'h46;
  localparam logic [3:0] RST_FAN_COUNT = 4'h9;
  // Voltages in 0.1 V, ramp spans in degrees C, ramp steps in 0.1 V per degree
  localparam logic [8:0] VOLT_OFF = 9'h000;
  localparam logic [8:0] VOLT_MIN = 9'h078;
  localparam logic [8:0] VOLT_IDLE = 9'h082;
  localparam logic [8:0] VOLT_FULL = 9'h0f0;
  localparam logic [7:0] SLOPE_NARROW = 8'h05;
  localparam logic [7:0] SLOPE_WIDE = 8'h0a;
  localparam logic [8:0] STEP_NARROW = 9'h016;
  localparam logic [8:0] STEP_WIDE = 9'h00b;
  // Tach window and threshold
  localparam int CLK_KHZ = 10000;
  localparam int TACH_WIN_MS = 3000;
  localparam int TACH_WIN_CYC = TACH_WIN_MS * CLK_KHZ;
  localparam int FAN_ALARM_PPM = 2000;
  localparam int TACH_MIN_PULSES = FAN_ALARM_PPM * TACH_WIN_MS / 60000;

  typedef enum logic {MODE_TEMP = 1'b0, MODE_CMD = 1'b1} fsac_mode_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsac_req_t;

  typedef struct packed {
    logic [7:0] temp;
    logic fault;
  } fsac_sensor_t;
endpackage : fsac_pkg

// [fsac_top.sv]
// Purpose: Fan voltage setpoint, tach monitor and alarm outputs
// Assumes: Register port and sensor inputs on mclk_i; tach and fault pins async
// Notes: All state in one struct, registered once per clock
`timescale 1ns/1ns
`default_nettype none
module fsac_top #(
  parameter int WIN_CYC = fsac_pkg::TACH_WIN_CYC,
  parameter int MIN_PULSES = fsac_pkg::TACH_MIN_PULSES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire fsac_pkg::fsac_req_t req_i,
  input wire fsac_pkg::fsac_sensor_t remote_i,
  input wire fsac_pkg::fsac_sensor_t local_i,
  input wire logic [8:0] tach_i,
  input wire logic ctrl_fail_i,
  input wire logic power_loss_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [8:0] volt_set_o,
  output logic reg_en_o,
  output logic [8:0] fan_pwr_o,
  output logic led_alarm_o,
  output logic alarm_relay_o
);
  if (WIN_CYC < 2 || MIN_PULSES < 1 || MIN_PULSES > 255)
  begin : g_bad_param
    $error("fsac_top: unsupported window or pulse threshold");
  end

  typedef struct packed {
    logic [8:0] tach_s1;
    logic [8:0] tach_s2;
    logic [8:0] tach_prev;
    logic [1:0] flt_s1;
    logic [1:0] flt_s2;
    logic [8:0][7:0] cnt;
    logic [31:0] win;
    logic [8:0] fan_fail;
    fsac_pkg::fsac_mode_t mode;
    logic [7:0] ctrl;
    logic [7:0] full_temp;
    logic [7:0] off_temp;
    logic [7:0] alarm_temp;
    logic [3:0] fan_count;
    logic [7:0] speed_cmd;
    logic [7:0] rdata;
    logic rvalid;
    logic [8:0] volt;
    logic reg_en;
    logic [8:0] fan_pwr;
    logic over_temp;
    logic alarm;
  } fsac_state_t;

  fsac_state_t st;
  fsac_state_t next_st;

  // Ramp from idle to full over the chosen span below control temp
  function automatic logic [8:0] temp_volt(input logic [7:0] t,
                                           input logic [7:0] tc,
                                           input logic wide);
    logic [7:0] span;
    logic [7:0] base;
    logic [8:0] diff;
    logic [8:0] step;
    span = wide ? fsac_pkg::SLOPE_WIDE : fsac_pkg::SLOPE_NARROW;
    step = wide ? fsac_pkg::STEP_WIDE : fsac_pkg::STEP_NARROW;
    base = (tc > span) ? tc - span : 8'h00;
    diff = {1'b0, t - base};
    if (t >= tc)
      temp_volt = fsac_pkg::VOLT_FULL; // see RULE_04
    else if (t < base)
      temp_volt = fsac_pkg::VOLT_IDLE; // see RULE_12
    else
      temp_volt = 9'(fsac_pkg::VOLT_IDLE + 9'(diff * step)); // see RULE_05
  endfunction : temp_volt

  // Clamp a nonzero command into the operating span
  function automatic logic [8:0] cmd_volt(input logic [7:0] c);
    if (c == 8'h00)
      cmd_volt = fsac_pkg::VOLT_OFF;
    else if ({1'b0, c} < fsac_pkg::VOLT_MIN)
      cmd_volt = fsac_pkg::VOLT_MIN; // see RULE_10
    else if ({1'b0, c} > fsac_pkg::VOLT_FULL)
      cmd_volt = fsac_pkg::VOLT_FULL; // see RULE_10
    else
      cmd_volt = {1'b0, c};
  endfunction : cmd_volt

  logic [7:0] sel_temp;
  logic sel_fault;
  logic [8:0] fan_en;
  logic [8:0] tach_rise;
  logic win_end;
  logic fan_alarm;
  logic sensor_alarm;

  always_comb
  begin
    next_st = st;
    sel_temp = st.ctrl[fsac_pkg::CTRL_SENSOR_LOCAL] ? local_i.temp
                                                    : remote_i.temp; // see RULE_06
    sel_fault = st.ctrl[fsac_pkg::CTRL_SENSOR_LOCAL] ? local_i.fault
                                                     : remote_i.fault;
    for (int i = 0; i < fsac_pkg::NUM_FANS; i++)
      fan_en[i] = (4'(i) < st.fan_count); // see RULE_09
    tach_rise = st.tach_s2 & ~st.tach_prev;
    win_end = (st.win == 32'(WIN_CYC - 1));

    // Input synchronisers
    next_st.tach_s1 = tach_i;
    next_st.tach_s2 = st.tach_s1;
    next_st.tach_prev = st.tach_s2;
    next_st.flt_s1 = {power_loss_i, ctrl_fail_i};
    next_st.flt_s2 = st.flt_s1;

    // Tach window
    next_st.win = win_end ? 32'h0 : st.win + 32'h1;
    for (int i = 0; i < fsac_pkg::NUM_FANS; i++)
    begin
      if (win_end)
      begin
        next_st.fan_fail[i] = fan_en[i] &&
                              (st.cnt[i] < 8'(MIN_PULSES)); // see RULE_21
        next_st.cnt[i] = 8'h00;
      end
      else if (tach_rise[i] && st.cnt[i] != 8'hff)
        next_st.cnt[i] = st.cnt[i] + 8'h01;
      if (!fan_en[i])
        next_st.fan_fail[i] = 1'b0; // see RULE_19
    end

    // Register writes
    next_st.rvalid = req_i.re;
    if (req_i.we)
    begin
      unique case (req_i.addr)
        fsac_pkg::REG_CTRL: next_st.ctrl = req_i.wdata; // see RULE_17
        fsac_pkg::REG_OFF_TEMP: next_st.off_temp = req_i.wdata;
        fsac_pkg::REG_ALARM_TEMP: next_st.alarm_temp = req_i.wdata;
        fsac_pkg::REG_FULL_SPEED_TEMP: next_st.full_temp = req_i.wdata;
        fsac_pkg::REG_FAN_COUNT:
        begin
          if (req_i.wdata >= 8'h01 && req_i.wdata <= 8'h09)
            next_st.fan_count = req_i.wdata[3:0]; // see RULE_09
        end
        fsac_pkg::REG_SPEED_CMD:
        begin
          next_st.speed_cmd = req_i.wdata; // see RULE_02
          next_st.mode = fsac_pkg::MODE_CMD; // see RULE_01
        end
        default: ;
      endcase
    end

    // Register reads
    if (req_i.re)
    begin
      unique case (req_i.addr)
        fsac_pkg::REG_CTRL: next_st.rdata = st.ctrl;
        fsac_pkg::REG_OFF_TEMP: next_st.rdata = st.off_temp;
        fsac_pkg::REG_ALARM_TEMP: next_st.rdata = st.alarm_temp;
        fsac_pkg::REG_FULL_SPEED_TEMP: next_st.rdata = st.full_temp;
        fsac_pkg::REG_FAN_COUNT: next_st.rdata = {4'h0, st.fan_count};
        fsac_pkg::REG_SPEED_CMD: next_st.rdata = st.speed_cmd;
        fsac_pkg::REG_STATUS:
          next_st.rdata = {3'h0, st.flt_s2, st.alarm, st.over_temp,
                           st.mode};
        fsac_pkg::REG_REMOTE_TEMP: next_st.rdata = remote_i.temp; // see RULE_16
        fsac_pkg::REG_LOCAL_TEMP: next_st.rdata = local_i.temp; // see RULE_20
        fsac_pkg::REG_SENSOR_STAT:
          next_st.rdata = {6'h00, local_i.fault, remote_i.fault}; // see RULE_16
        fsac_pkg::REG_FAN_FAIL_LO: next_st.rdata = st.fan_fail[7:0]; // see RULE_18
        fsac_pkg::REG_FAN_FAIL_HI:
          next_st.rdata = {7'h00, st.fan_fail[8]}; // see RULE_18
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Setpoint and regulator enable
    next_st.over_temp = 1'b0;
    if (st.mode == fsac_pkg::MODE_CMD)
      next_st.volt = cmd_volt(st.speed_cmd); // see RULE_20
    else
    begin
      next_st.volt = temp_volt(sel_temp, st.full_temp,
                               st.ctrl[fsac_pkg::CTRL_SLOPE_10]); // see RULE_03
      if (st.ctrl[fsac_pkg::CTRL_OFF_EN] && sel_temp < st.off_temp)
        next_st.volt = fsac_pkg::VOLT_OFF; // see RULE_07
      if (sel_temp > st.alarm_temp)
      begin
        next_st.over_temp = 1'b1; // see RULE_08
        next_st.volt = fsac_pkg::VOLT_FULL;
      end
    end
    if (st.ctrl[fsac_pkg::CTRL_REG_OFF])
      next_st.volt = fsac_pkg::VOLT_OFF; // see RULE_17
    next_st.reg_en = (next_st.volt != fsac_pkg::VOLT_OFF); // see RULE_10
    next_st.fan_pwr = fan_en & {9{next_st.reg_en}}; // see RULE_09

    // Alarms
    fan_alarm = |st.fan_fail; // see RULE_13
    sensor_alarm = (st.mode == fsac_pkg::MODE_TEMP) && sel_fault; // see RULE_14
    next_st.alarm = fan_alarm | st.over_temp | sensor_alarm |
                    st.flt_s2[0] | st.flt_s2[1]; // see RULE_15
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      st <= '0;
      st.mode <= fsac_pkg::MODE_TEMP; // see RULE_11
      st.ctrl <= fsac_pkg::RST_CTRL;
      st.full_temp <= fsac_pkg::RST_FULL_SPEED_TEMP; // see RULE_11
      st.off_temp <= fsac_pkg::RST_OFF_TEMP;
      st.alarm_temp <= fsac_pkg::RST_ALARM_TEMP;
      st.fan_count <= fsac_pkg::RST_FAN_COUNT; // see RULE_13
    end
    else
      st <= next_st;
  end

  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign volt_set_o = st.volt;
  assign reg_en_o = st.reg_en;
  assign fan_pwr_o = st.fan_pwr;
  assign led_alarm_o = st.alarm;
  assign alarm_relay_o = st.alarm;
endmodule : fsac_top
`default_nettype wire

// [fsac_chk.sv]
// Purpose: Port assertions for the fan speed and alarm controller
// Assumes: All ports sampled on mclk_i, sync active-low reset
// Notes: Bound to every fsac_top instance
`timescale 1ns/1ns
`default_nettype none
module fsac_chk #(
  parameter int WIN_CYC = 200,
  parameter int MIN_PULSES = 3
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire fsac_pkg::fsac_req_t req_i,
  input wire fsac_pkg::fsac_sensor_t remote_i,
  input wire fsac_pkg::fsac_sensor_t local_i,
  input wire logic [8:0] tach_i,
  input wire logic ctrl_fail_i,
  input wire logic power_loss_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [8:0] volt_set_o,
  input wire logic reg_en_o,
  input wire logic [8:0] fan_pwr_o,
  input wire logic led_alarm_o,
  input wire logic alarm_relay_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic wr_cmd;
  logic wr_ctl;
  logic off_bit;
  assign wr_cmd = req_i.we && req_i.addr == fsac_pkg::REG_SPEED_CMD;
  assign wr_ctl = req_i.we && req_i.addr == fsac_pkg::REG_CTRL;
  // Shadow of the regulator-off bit
  always_ff @(posedge mclk_i)
    if (!resetn_i)
      off_bit <= 1'b0;
    else if (wr_ctl)
      off_bit <= req_i.wdata[fsac_pkg::CTRL_REG_OFF];
  property p_rd; req_i.re |=> rvalid_o; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_nord; !req_i.re |=> !rvalid_o; endproperty
  a_nord: assert property (p_nord) else $error("stray rvalid");
  property p_span; volt_set_o == 9'h000 ||
    (volt_set_o >= 9'h078 && volt_set_o <= 9'h0f0); endproperty
  a_span: assert property (p_span) else $error("setpoint gap");
  property p_en; reg_en_o == (volt_set_o != 9'h000); endproperty
  a_en: assert property (p_en) else $error("enable mismatch");
  property p_relay; alarm_relay_o == led_alarm_o; endproperty
  a_relay: assert property (p_relay) else $error("relay differs");
  property p_pwr; (fan_pwr_o & ~{9{reg_en_o}}) == 9'h000; endproperty
  a_pwr: assert property (p_pwr) else $error("fan powered off");
  property p_cmd; wr_cmd && !off_bit && req_i.wdata >= 8'h78 &&
    req_i.wdata <= 8'hf0 ##1 !req_i.we
    |=> volt_set_o == {1'b0, $past(req_i.wdata, 2)}; endproperty
  a_cmd: assert property (p_cmd) else $error("command setpoint");
  property p_off; wr_ctl && req_i.wdata[2] ##1 !req_i.we
    |=> volt_set_o == 9'h000 && !reg_en_o; endproperty
  a_off: assert property (p_off) else $error("regulator on");
  property p_pl; power_loss_i [*5] |-> led_alarm_o; endproperty
  a_pl: assert property (p_pl) else $error("no power alarm");
endmodule : fsac_chk
bind fsac_top fsac_chk #(.WIN_CYC(WIN_CYC), .MIN_PULSES(MIN_PULSES)) u_chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i),
  .remote_i(remote_i), .local_i(local_i), .tach_i(tach_i),
  .ctrl_fail_i(ctrl_fail_i), .power_loss_i(power_loss_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .volt_set_o(volt_set_o),
  .reg_en_o(reg_en_o), .fan_pwr_o(fan_pwr_o),
  .led_alarm_o(led_alarm_o), .alarm_relay_o(alarm_relay_o));
`default_nettype wire

// [fsac_host.sv]
// Purpose: Management controller model on the register port
// Assumes: One-cycle strobes, answer one cycle after a read
// Notes: Idle address and data are inverted, never left stale
`timescale 1ns/1ns
`default_nettype none
module fsac_host (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  output var fsac_pkg::fsac_req_t req_o
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) #1;
    req_o = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i) #1;
    req_o = '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge mclk_i) #1;
    req_o = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i) #1;
    req_o = '{we: 1'b0, re: 1'b0, addr: ~a, wdata: 8'hff};
    d = rdata_o;
    v = rvalid_o;
  endtask : rd
endmodule : fsac_host
`default_nettype wire

// [test_fsac_top.sv]
// Purpose: Self-checking bench for the fan speed and alarm controller
// Assumes: Short tach window of 200 cycles, 3 pulses minimum
// Notes: Tach pins follow an 800 ns clock gated per fan
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_fsac_top;
  logic mclk_i = 0, resetn_i = 0, ctrl_fail_i = 0, power_loss_i = 0;
  logic tclk = 0, rvalid_o, reg_en_o, led_alarm_o, alarm_relay_o, v;
  fsac_pkg::fsac_req_t req_i;
  fsac_pkg::fsac_sensor_t remote_i = '0, local_i = '0;
  logic [8:0] tach_on = '1, tach_i, volt_set_o, fan_pwr_o;
  logic [7:0] rdata_o, d;
  int n_errors = 0, compares = 0, cyc = 0;
  always #50 mclk_i = ~mclk_i;
  initial #37 forever #400 tclk = ~tclk;
  assign tach_i = tach_on & {9{tclk}};
  fsac_host host (.mclk_i(mclk_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .req_o(req_i));
  fsac_top #(.WIN_CYC(200), .MIN_PULSES(3)) uut (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .req_i(req_i), .remote_i(remote_i),
    .local_i(local_i), .tach_i(tach_i), .ctrl_fail_i(ctrl_fail_i),
    .power_loss_i(power_loss_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .volt_set_o(volt_set_o), .reg_en_o(reg_en_o), .fan_pwr_o(fan_pwr_o),
    .led_alarm_o(led_alarm_o), .alarm_relay_o(alarm_relay_o));
  task automatic end_of_test;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  always @(posedge mclk_i)
    if (++cyc == 6000)
    begin
      n_errors++;
      end_of_test();
    end
  task automatic wait_c(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wait_c
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask : rchk
  task automatic vchk(input logic [7:0] t, input logic [8:0] e);
    remote_i.temp = t;
    wait_c(4);
    `CHK(volt_set_o, e)
  endtask : vchk
  task automatic t_temp;
    rchk(fsac_pkg::REG_FULL_SPEED_TEMP, 8'h28);
    rchk(8'h10, 8'h00);
    vchk(8'h1e, 9'h082);
    vchk(8'h26, 9'h0c4);
    vchk(8'h28, 9'h0f0);
    host.wr(fsac_pkg::REG_FULL_SPEED_TEMP, 8'h32);
    vchk(8'h28, 9'h082);
    host.wr(fsac_pkg::REG_CTRL, 8'h02);
    vchk(8'h2d, 9'h0b9);
    host.wr(fsac_pkg::REG_CTRL, 8'h03);
    local_i.temp = 8'h32;
    vchk(8'h1e, 9'h0f0);
    host.wr(fsac_pkg::REG_OFF_TEMP, 8'h19);
    host.wr(fsac_pkg::REG_CTRL, 8'h08);
    vchk(8'h14, 9'h000);
    host.wr(fsac_pkg::REG_FULL_SPEED_TEMP, 8'h64);
    vchk(8'h47, 9'h0f0);
    `CHK(led_alarm_o, 1'b1)
    vchk(8'h1e, 9'h082);
    $display("t_temp done");
  endtask : t_temp
  task automatic t_fans;
    wait_c(600);
    `CHK(led_alarm_o, 1'b0)
    tach_on[3] = 1'b0;
    wait_c(600);
    `CHK(led_alarm_o, 1'b1)
    rchk(fsac_pkg::REG_FAN_FAIL_LO, 8'h08);
    host.wr(fsac_pkg::REG_FAN_COUNT, 8'h03);
    host.wr(fsac_pkg::REG_FAN_COUNT, 8'h00);
    wait_c(4);
    `CHK(fan_pwr_o, 9'h007)
    `CHK(led_alarm_o, 1'b0)
    tach_on = '1;
    host.wr(fsac_pkg::REG_FAN_COUNT, 8'h09);
    wait_c(600);
    `CHK(fan_pwr_o, 9'h1ff)
    $display("t_fans done");
  endtask : t_fans
  task automatic t_fault;
    remote_i.fault = 1'b1;
    wait_c(4);
    `CHK(led_alarm_o, 1'b1)
    rchk(fsac_pkg::REG_SENSOR_STAT, 8'h01);
    remote_i.fault = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      {ctrl_fail_i, power_loss_i} = 2'b01 << i;
      wait_c(6);
      `CHK(alarm_relay_o, 1'b1)
      {ctrl_fail_i, power_loss_i} = 2'b00;
      wait_c(6);
      `CHK(alarm_relay_o, 1'b0)
    end
    $display("t_fault done");
  endtask : t_fault
  task automatic t_cmd;
    host.wr(fsac_pkg::REG_SPEED_CMD, 8'hc8);
    vchk(8'h64, 9'h0c8);
    `CHK(led_alarm_o, 1'b0)
    rchk(fsac_pkg::REG_REMOTE_TEMP, 8'h64);
    rchk(fsac_pkg::REG_LOCAL_TEMP, 8'h32);
    rchk(fsac_pkg::REG_STATUS, 8'h01);
    host.wr(fsac_pkg::REG_SPEED_CMD, 8'h32);
    vchk(8'h64, 9'h078);
    host.wr(fsac_pkg::REG_SPEED_CMD, 8'h00);
    vchk(8'h64, 9'h000);
    host.wr(fsac_pkg::REG_SPEED_CMD, 8'hff);
    vchk(8'h64, 9'h0f0);
    host.wr(fsac_pkg::REG_CTRL, 8'h04);
    vchk(8'h64, 9'h000);
    $display("t_cmd done");
  endtask : t_cmd
  initial
  begin
    wait_c(6);
    resetn_i = 1'b1;
    t_temp();
    t_fans();
    t_fault();
    t_cmd();
    end_of_test();
  end
endmodule : test_fsac_top
`default_nettype wire
